// >>> core/wake_on_lan_detector.sv
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "wol_params.svh"
module wake_on_lan_detector import wol_pkg::*; #(
  parameter int IDX_W = 11
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Avalon-MM register slave
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Receive byte stream from the MAC
  input  wire rx_byte_s    rx_in,
  // PHY link status pin
  input  wire logic        phy_link_up,
  // Status outputs
  output logic             rx_buffer_en,
  output logic             wake_indication,
  output logic             irq
);
  // Registers
  logic [7:0]  page_command;
  logic [31:0] byte_mask [4];
  logic [31:0] crc_pair [2];
  logic [31:0] wake_pattern_offsets;
  logic [31:0] wake_last_bytes;
  logic [31:0] wake_filter_commands;
  logic [2:0]  wake_enables;
  logic [2:0]  wake_status;
  logic [7:0]  power_mgmt;
  logic [2:0]  int_mask;
  logic [7:0]  buffer_type_ctrl;
  logic [47:0] station_addr;

  // Bus decode
  logic [4:0]  reg_idx;
  logic        wake_page;
  logic        wr_go;
  logic [7:0]  wr_byte;
  logic [31:0] next_readdata;

  // Wake mode and frame tracking
  logic             wake_mode;
  frame_state_e     frame_state;
  frame_state_e     next_frame_state;
  logic [IDX_W-1:0] byte_cnt;
  logic [IDX_W-1:0] cur_idx;
  rx_byte_s         rx_gated;
  logic             da_ok;
  logic             frame_done;
  logic             frame_good;

  // Detectors and events
  filter_cfg_s cfg [4];
  logic [3:0]  filt_hit;
  logic [3:0]  filt_en;
  logic [3:0]  pat_ok;
  logic [3:0]  chain_done;
  logic [3:0]  next_chain_done;
  logic [3:0]  pending;
  logic [3:0]  target;
  logic        cascade;
  logic        magic_hit;
  logic        ev_pattern;
  logic        ev_magic;
  logic        ev_link;
  logic [2:0]  clr_status;
  logic [2:0]  next_status;

  // Link pin synchroniser
  logic link_s1;
  logic link_s2;
  logic link_s3;
  logic link_level;
  logic link_change;

  function automatic logic [31:0] shift_in(input logic [31:0] old,
                                           input logic [7:0]  b);
    return {b, old[31:8]};
  endfunction

  function automatic logic reg_hit(input logic [4:0] idx,
                                   input logic [4:0] want,
                                   input logic       page_ok);
    return (idx == want) && (page_ok || want == `IDX_PAGE_CMD);
  endfunction

  assign reg_idx   = avs_address[6:2];
  // Wake registers respond only while page 3 is selected
  assign wake_page = (page_command[`PAGE_SEL_HI -: 2] == `PAGE_WAKE);
  assign wr_go     = avs_write && !avs_waitrequest && avs_byteenable[0] &&
                     (avs_address[1:0] == 2'h0);
  assign wr_byte   = avs_writedata[7:0];

  // One wait state on every access
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_comb begin
    next_readdata = 32'h0;
    if (avs_address[1:0] != 2'h0) begin
      next_readdata = 32'h0;
    end else if (reg_hit(reg_idx, `IDX_PAGE_CMD, wake_page)) begin
      next_readdata = {24'h0, page_command};
    end else if (!wake_page) begin
      next_readdata = 32'h0;
    end else if (reg_idx >= `IDX_BYTE_MASK0 && reg_idx < `IDX_CRC_LOW) begin
      next_readdata = byte_mask[2'(reg_idx - `IDX_BYTE_MASK0)];
    end else if (reg_idx == `IDX_CRC_LOW) begin
      next_readdata = crc_pair[0];
    end else if (reg_idx == `IDX_CRC_HIGH) begin
      next_readdata = crc_pair[1];
    end else if (reg_idx == `IDX_OFFSETS) begin
      next_readdata = wake_pattern_offsets;
    end else if (reg_idx == `IDX_LAST_BYTES) begin
      next_readdata = wake_last_bytes;
    end else if (reg_idx == `IDX_COMMANDS) begin
      next_readdata = wake_filter_commands;
    end else if (reg_idx == `IDX_WAKE_CS) begin
      next_readdata = {25'h0, wake_status, 1'b0, wake_enables};
    end else if (reg_idx == `IDX_POWER) begin
      next_readdata = {24'h0, power_mgmt};
    end else if (reg_idx == `IDX_INT_MASK) begin
      next_readdata = {25'h0, int_mask, 4'h0};
    end else if (reg_idx == `IDX_STATION) begin
      next_readdata = station_addr[31:0];
    end else if (reg_idx == `IDX_BUF_TYPE) begin
      next_readdata = {24'h0, buffer_type_ctrl};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // Page select, always reachable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      page_command <= `REG8_RST;
    end else if (wr_go && reg_hit(reg_idx, `IDX_PAGE_CMD, 1'b1)) begin
      page_command <= wr_byte;
    end
  end

  // Filter tables, loaded a byte at a time from the top
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) byte_mask[i] <= `REG32_RST;
      crc_pair[0]          <= `REG32_RST;
      crc_pair[1]          <= `REG32_RST;
      wake_pattern_offsets <= `REG32_RST;
      wake_last_bytes      <= `REG32_RST;
      wake_filter_commands <= `REG32_RST;
    end else if (wr_go && wake_page) begin
      for (int i = 0; i < 4; i++) begin
        if (reg_idx == `IDX_BYTE_MASK0 + 5'(i)) begin
          byte_mask[i] <= shift_in(byte_mask[i], wr_byte);
        end
      end
      if (reg_idx == `IDX_CRC_LOW) begin
        crc_pair[0] <= shift_in(crc_pair[0], wr_byte);
      end
      if (reg_idx == `IDX_CRC_HIGH) begin
        crc_pair[1] <= shift_in(crc_pair[1], wr_byte);
      end
      if (reg_idx == `IDX_OFFSETS) begin
        wake_pattern_offsets <= shift_in(wake_pattern_offsets, wr_byte);
      end
      if (reg_idx == `IDX_LAST_BYTES) begin
        wake_last_bytes <= shift_in(wake_last_bytes, wr_byte);
      end
      if (reg_idx == `IDX_COMMANDS) begin
        wake_filter_commands <= shift_in(wake_filter_commands, wr_byte);
      end
    end
  end

  // Station address, six writes, first byte ends lowest
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      station_addr <= 48'h0;
    end else if (wr_go && reg_hit(reg_idx, `IDX_STATION, wake_page)) begin
      station_addr <= {wr_byte, station_addr[47:8]};
    end
  end

  // Control bytes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_enables     <= 3'h0;
      power_mgmt       <= `REG8_RST;
      int_mask         <= 3'h0;
      buffer_type_ctrl <= `REG8_RST;
    end else if (wr_go && wake_page) begin
      if (reg_idx == `IDX_WAKE_CS) begin
        wake_enables <= wr_byte[2:0];
      end
      if (reg_idx == `IDX_POWER) begin
        power_mgmt <= wr_byte;
      end
      if (reg_idx == `IDX_INT_MASK) begin
        int_mask <= wr_byte[`WCS_ST_LO +: 3];
      end
      if (reg_idx == `IDX_BUF_TYPE) begin
        buffer_type_ctrl <= wr_byte;
      end
    end
  end

  assign wake_mode = (|wake_enables) &&
                     (power_mgmt[1:0] == `PM_LIGHT_SLEEP);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_buffer_en <= 1'b1;
    end else begin
      rx_buffer_en <= !wake_mode;
    end
  end

  // Frame tracking, only while detecting
  always_comb begin
    rx_gated       = rx_in;
    rx_gated.valid = rx_in.valid && wake_mode &&
                     (rx_in.sof || frame_state == FRAME_RECV);
    cur_idx        = rx_in.sof ? '0 : byte_cnt;
    next_frame_state = frame_state;
    case (frame_state)
      FRAME_IDLE: begin
        if (rx_gated.valid && !rx_in.eof) next_frame_state = FRAME_RECV;
      end
      FRAME_RECV: begin
        if (!wake_mode) next_frame_state = FRAME_IDLE;
        else if (rx_gated.valid && rx_in.eof) next_frame_state = FRAME_IDLE;
      end
      default: next_frame_state = FRAME_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_state <= FRAME_IDLE;
      byte_cnt    <= '0;
    end else begin
      frame_state <= next_frame_state;
      if (rx_gated.valid && cur_idx != '1) byte_cnt <= cur_idx + 1'b1;
    end
  end

  // Destination address filter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      da_ok <= 1'b0;
    end else if (rx_gated.valid && cur_idx < IDX_W'(6)) begin
      da_ok <= (rx_in.sof || da_ok) &&
               (rx_in.data == station_addr[{cur_idx[2:0], 3'h0} +: 8]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      frame_done <= 1'b0;
      frame_good <= 1'b0;
    end else begin
      frame_done <= rx_gated.valid && rx_in.eof;
      if (rx_gated.valid && rx_in.eof) frame_good <= rx_in.fcs_ok;
    end
  end

  // Four pattern filters
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_filter
      assign cfg[g].mask      = byte_mask[g];
      assign cfg[g].offset    = wake_pattern_offsets[8*g +: 8];
      assign cfg[g].last_byte = wake_last_bytes[8*g +: 8];
      assign cfg[g].crc       = crc_pair[g/2][16*(g%2) +: 16];
      assign filt_en[g]       = wake_filter_commands[8*g + `CMD_ENABLE];
      assign pat_ok[g] = filt_hit[g] && filt_en[g] && frame_good &&
                         (!wake_filter_commands[8*g + `CMD_DA_MATCH] ||
                          da_ok);

      wake_pattern_filter #(
        .IDX_W (IDX_W)
      ) u_filter (
        .clk      (clk),
        .resetn   (resetn),
        .rx_in    (rx_gated),
        .byte_idx (cur_idx),
        .cfg      (cfg[g]),
        .hit      (filt_hit[g])
      );
    end
  endgenerate

  wake_magic_detector u_magic (
    .clk     (clk),
    .resetn  (resetn),
    .rx_in   (rx_gated),
    .station (station_addr),
    .hit     (magic_hit)
  );

  // Parallel or chained pattern matching
  assign cascade = wake_filter_commands[`CMD_CASCADE];
  assign pending = filt_en & ~chain_done;
  assign target  = pending & (~pending + 4'h1);

  always_comb begin
    next_chain_done = chain_done;
    ev_pattern      = 1'b0;
    if (!wake_mode || !cascade) begin
      next_chain_done = 4'h0;
      ev_pattern = wake_mode && wake_enables[`WCS_PAT_EN] && frame_done &&
                   (|pat_ok);
    end else if (frame_done && (|(pat_ok & target))) begin
      next_chain_done = chain_done | target;
      if ((next_chain_done & filt_en) == filt_en) begin
        next_chain_done = 4'h0;
        ev_pattern      = wake_enables[`WCS_PAT_EN];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      chain_done <= 4'h0;
    end else begin
      chain_done <= next_chain_done;
    end
  end

  // Link pin: a change counts once stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link_s1    <= 1'b0;
      link_s2    <= 1'b0;
      link_s3    <= 1'b0;
      link_level <= 1'b0;
    end else begin
      link_s1 <= phy_link_up;
      link_s2 <= link_s1;
      link_s3 <= link_s2;
      if (link_s2 == link_s3) link_level <= link_s3;
    end
  end

  assign link_change = (link_s2 == link_s3) && (link_s3 != link_level);

  // Wake events, sticky status, set beats clear
  assign ev_magic = wake_mode && wake_enables[`WCS_MAGIC_EN] &&
                    magic_hit && frame_good;
  assign ev_link  = wake_mode && wake_enables[`WCS_LINK_EN] &&
                    link_change;
  assign clr_status = (wr_go && reg_hit(reg_idx, `IDX_WAKE_CS, wake_page)) ?
                      wr_byte[`WCS_ST_LO +: 3] : 3'h0;
  assign next_status = (wake_status & ~clr_status) |
                       {ev_link, ev_magic, ev_pattern};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wake_status     <= 3'h0;
      wake_indication <= 1'b0;
      irq             <= 1'b0;
    end else begin
      wake_status     <= next_status;
      wake_indication <= |next_status;
      irq             <= |(next_status & int_mask);
    end
  end
endmodule

// >>> core/wol_params.svh
`ifndef WOL_PARAMS_SVH
`define WOL_PARAMS_SVH

// Register indices, byte address is four times the index
`define IDX_PAGE_CMD   5'h00
`define IDX_BYTE_MASK0 5'h01
`define IDX_CRC_LOW    5'h05
`define IDX_CRC_HIGH   5'h06
`define IDX_OFFSETS    5'h07
`define IDX_LAST_BYTES 5'h08
`define IDX_COMMANDS   5'h09
`define IDX_WAKE_CS    5'h0A
`define IDX_POWER      5'h0B
`define IDX_INT_MASK   5'h0C
`define IDX_STATION    5'h10
`define IDX_BUF_TYPE   5'h15
// Field positions and values
`define PAGE_SEL_HI    7
`define PAGE_WAKE      2'h3
`define PM_LIGHT_SLEEP 2'h1
`define WCS_MAGIC_EN   0
`define WCS_PAT_EN     1
`define WCS_LINK_EN    2
`define WCS_ST_LO      4
`define CMD_ENABLE     0
`define CMD_DA_MATCH   1
`define CMD_CASCADE    31
`define REG8_RST       8'h00
`define REG32_RST      32'h0000_0000
// Pattern check value and repeated-address frame
`define CRC_INIT       16'hFFFF
`define CRC_POLY_REV   16'hA001
`define MAGIC_SYNC     3'h6
`define MAGIC_REPS     5'h10
`endif

// >>> core/wol_pkg.sv
package wol_pkg;
  typedef struct packed {
    logic       valid;
    logic       sof;
    logic       eof;
    logic       fcs_ok;
    logic [7:0] data;
  } rx_byte_s;

  typedef struct packed {
    logic [31:0] mask;
    logic [7:0]  offset;
    logic [7:0]  last_byte;
    logic [15:0] crc;
  } filter_cfg_s;

  typedef enum logic [0:0] {
    FRAME_IDLE = 1'b0,
    FRAME_RECV = 1'b1
  } frame_state_e;
endpackage

// >>> core/wake_pattern_filter.sv
`timescale 1ns/10ps
`include "wol_params.svh"
module wake_pattern_filter import wol_pkg::*; #(
  parameter int IDX_W = 11
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Frame bytes and position
  input  wire rx_byte_s         rx_in,
  input  wire logic [IDX_W-1:0] byte_idx,
  // Setup and result
  input  wire filter_cfg_s      cfg,
  output logic                  hit
);
  logic [15:0]      crc;
  logic [15:0]      next_crc;
  logic             last_ok;
  logic             next_last_ok;
  logic [IDX_W-1:0] start;
  logic [IDX_W-1:0] rel;
  logic             in_win;

  function automatic logic [15:0] crc16_step(input logic [15:0] c,
                                             input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int b = 0; b < 8; b++) begin
      r = (r[0] ^ d[b]) ? ((r >> 1) ^ `CRC_POLY_REV) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic [4:0] top_bit(input logic [31:0] m);
    logic [4:0] t;
    t = 5'h0;
    for (int j = 0; j < 32; j++) begin
      if (m[j]) t = 5'(j);
    end
    return t;
  endfunction

  assign start  = IDX_W'({cfg.offset, 1'b0});
  assign rel    = byte_idx - start;
  assign in_win = (byte_idx >= start) && (rel < IDX_W'(32));

  always_comb begin
    next_crc     = rx_in.sof ? `CRC_INIT : crc;
    next_last_ok = rx_in.sof ? 1'b0 : last_ok;
    if (rx_in.valid && in_win && cfg.mask[rel[4:0]]) begin
      next_crc = crc16_step(next_crc, rx_in.data);
    end
    if (rx_in.valid && in_win && rel[4:0] == top_bit(cfg.mask)) begin
      next_last_ok = (rx_in.data == cfg.last_byte);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc     <= `CRC_INIT;
      last_ok <= 1'b0;
      hit     <= 1'b0;
    end else begin
      if (rx_in.valid) begin
        crc     <= next_crc;
        last_ok <= next_last_ok;
      end
      hit <= rx_in.valid && rx_in.eof && (cfg.mask != 32'h0) &&
             (next_crc == cfg.crc) && next_last_ok;
    end
  end
endmodule

// >>> core/wake_magic_detector.sv
`timescale 1ns/10ps
`include "wol_params.svh"
module wake_magic_detector import wol_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Frame bytes and own address
  input  wire rx_byte_s    rx_in,
  input  wire logic [47:0] station,
  // Result at frame end
  output logic             hit
);
  logic [2:0] sync_cnt;
  logic [2:0] pos;
  logic [4:0] reps;
  logic       matching;
  logic       found;
  logic [2:0] next_sync;
  logic [2:0] next_pos;
  logic [4:0] next_reps;
  logic       next_matching;
  logic       next_found;

  always_comb begin
    next_sync     = rx_in.sof ? 3'h0 : sync_cnt;
    next_pos      = rx_in.sof ? 3'h0 : pos;
    next_reps     = rx_in.sof ? 5'h0 : reps;
    next_matching = rx_in.sof ? 1'b0 : matching;
    next_found    = rx_in.sof ? 1'b0 : found;
    if (next_matching && rx_in.data == station[{next_pos, 3'h0} +: 8]) begin
      next_pos = (next_pos == 3'h5) ? 3'h0 : next_pos + 3'h1;
      if (next_pos == 3'h0) next_reps = next_reps + 5'h1;
      if (next_reps == `MAGIC_REPS) begin
        next_found    = 1'b1;
        next_matching = 1'b0;
      end
    end else if (!next_matching && next_sync == `MAGIC_SYNC &&
                 rx_in.data == station[7:0]) begin
      next_matching = 1'b1;
      next_pos      = 3'h1;
      next_reps     = 5'h0;
    end else begin
      next_matching = 1'b0;
      if (rx_in.data != 8'hFF) next_sync = 3'h0;
      else if (next_sync != `MAGIC_SYNC) next_sync = next_sync + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_cnt <= 3'h0;
      pos      <= 3'h0;
      reps     <= 5'h0;
      matching <= 1'b0;
      found    <= 1'b0;
      hit      <= 1'b0;
    end else begin
      if (rx_in.valid) begin
        sync_cnt <= next_sync;
        pos      <= next_pos;
        reps     <= next_reps;
        matching <= next_matching;
        found    <= next_found;
      end
      hit <= rx_in.valid && rx_in.eof && next_found;
    end
  end
endmodule

// >>> bench/wol_checker_assertions.sv
`timescale 1ns/10ps
module wol_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Bus and status ports
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        rx_buffer_en,
  input wire logic        wake_indication,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire req = avs_read | avs_write;
  one_wait_a: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered after one wait");
  wait_pulse_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("wait low longer than one cycle");
  idle_wait_a: assert property (
    !req |=> avs_waitrequest)
    else $error("wait low without request");
  rdata_hold_a: assert property (
    !avs_read |=> $stable(avs_readdata))
    else $error("read data moved without read");
  irq_wake_a: assert property (irq |-> wake_indication)
    else $error("interrupt without wake status");
  wake_mode_a: assert property (
    $rose(wake_indication) |-> !rx_buffer_en)
    else $error("wake event outside wake mode");
  buf_off_a: assert property (
    $changed(rx_buffer_en) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("reception enable moved without write");
  wake_clear_a: assert property (
    $fell(wake_indication) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("wake status lost without write");
  irq_clear_a: assert property (
    $fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("interrupt dropped without write");
endmodule

// >>> bench/frame_source.sv
`timescale 1ns/10ps
module frame_source import wol_pkg::*; (
  // Clock
  input  wire logic clk,
  // Byte stream into the block
  output rx_byte_s  rx_out
);
  initial rx_out = '0;
  // Whole frame, good check sequence unless bad is set, flagged on every byte
  task automatic send(input logic [7:0] f[$], input bit bad = 1'b0);
    foreach (f[i]) begin
      @(posedge clk);
      rx_out <= '{1'b1, i == 0, i == f.size() - 1, !bad, f[i]};
    end
    @(posedge clk);
    // Idle data inverted so a stale byte is never reused
    rx_out <= '{1'b0, 1'b0, 1'b0, 1'b0, ~f[f.size() - 1]};
  endtask
endmodule

// >>> bench/wake_on_lan_detector_tb_top.sv
`timescale 1ns/10ps
module wake_on_lan_detector_tb_top;
  import wol_pkg::*;
  logic        clk = 0;
  logic        resetn = 0;
  logic [6:0]  avs_address = '0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        phy_link_up = 0;
  logic        rx_buffer_en;
  logic        wake_indication;
  logic        irq;
  rx_byte_s    rx_in;
  logic [31:0] expq[$];
  logic [7:0]  st[6];
  logic [7:0]  f[$];
  logic [7:0]  m[$];
  logic [15:0] c;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cyc = 0;
  always #12.5 clk = ~clk;
  wake_on_lan_detector i_wake_on_lan_detector (.clk, .resetn, .avs_address,
    .avs_read, .avs_write, .avs_byteenable(4'hF), .avs_writedata,
    .avs_readdata, .avs_waitrequest, .rx_in, .phy_link_up, .rx_buffer_en,
    .wake_indication, .irq);
  frame_source i_frame_source (.clk, .rx_out(rx_in));
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low
  task automatic bus(input bit wr, input logic [4:0] a, input logic [31:0] d);
    avs_address <= {a, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    if (!wr)
      expq.push_back(d);
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1, a, {24'h0, d});
  endtask
  task automatic wr32(input logic [4:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++)
      wr(a, v[8*i +: 8]);
  endtask
  task automatic flags(input logic [2:0] e);
    repeat (4) @(posedge clk);
    total_checks++;
    if ({irq, wake_indication, rx_buffer_en} !== e) begin
      num_errors++;
      $display("unexpected at %0t: flags %b not %b", $time,
        {irq, wake_indication, rx_buffer_en}, e);
    end
  endtask
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'b0)
      cmp(avs_readdata, expq.pop_front(), "read");
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    void'($urandom(76487));
    repeat (2) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    for (int i = 0; i < 64; i++)
      f.push_back(8'($urandom));
    for (int i = 0; i < 6; i++)
      st[i] = f[i];
    c = 16'hFFFF;
    for (int j = 0; j < 32; j++)
      if (32'h0040_0807 >> j & 1) begin
        c ^= {8'h00, f[12+j]};
        repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
    bus(0, 5'h0A, 0);
    wr(5'h00, 8'hC2);
    wr32(5'h01, 32'h0040_0807);
    bus(0, 5'h01, 32'h0040_0807);
    bus(0, 5'h1F, 0);
    for (int i = 0; i < 6; i++)
      wr(5'h10, st[i]);
    wr32(5'h05, {16'h0, c});
    wr32(5'h07, 32'h0000_0006);
    wr32(5'h08, {24'h0, ~f[34]});
    wr32(5'h09, 32'h0000_0003);
    wr(5'h0C, 8'h70);
    bus(0, 5'h0C, 32'h70);
    wr(5'h0A, 8'h02);
    wr(5'h0B, 8'h01);
    flags(3'b000);
    i_frame_source.send(f);
    flags(3'b000);
    wr32(5'h08, {24'h0, f[34]});
    i_frame_source.send(f);
    flags(3'b110);
    bus(0, 5'h0A, 32'h12);
    wr(5'h0A, 8'h12);
    bus(0, 5'h0A, 32'h02);
    $display("test pattern done");
    repeat (8) m.push_back(8'($urandom));
    repeat (6) m.push_back(8'hFF);
    repeat (16) foreach (st[i]) m.push_back(st[i]);
    repeat (4) m.push_back(8'h00);
    wr(5'h0A, 8'h03);
    i_frame_source.send(m);
    flags(3'b110);
    bus(0, 5'h0A, 32'h23);
    $display("test repeated address done");
    wr(5'h0A, 8'h24);
    bus(0, 5'h0A, 32'h04);
    phy_link_up <= 1;
    repeat (6) @(posedge clk);
    flags(3'b110);
    bus(0, 5'h0A, 32'h44);
    wr(5'h0C, 8'h00);
    flags(3'b010);
    $display("test link done");
    wr(5'h0A, 8'h42);
    wr32(5'h02, 32'h0040_0807);
    wr32(5'h05, {c, c});
    wr32(5'h07, 32'h0000_0606);
    wr32(5'h08, {16'h0, f[34], f[34]});
    wr32(5'h09, 32'h8000_0303);
    flags(3'b000);
    i_frame_source.send(f, 1'b1);
    flags(3'b000);
    i_frame_source.send(f);
    flags(3'b000);
    i_frame_source.send(f);
    flags(3'b010);
    bus(0, 5'h0A, 32'h12);
    $display("test cascade done");
    test_done();
  end
endmodule
bind wake_on_lan_detector wol_checker i_wol_checker (.clk, .resetn,
  .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .rx_buffer_en,
  .wake_indication, .irq);
